//--- test_transparent_xlate_and_status.sv
`timescale 1ns/100ps
`default_nettype none
`include "ttw_consts.svh"

module test_transparent_xlate_and_status;
   logic clk_sys = 1'b0, rst_n = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0;
   logic accValid = 1'b0, tcEnable = 1'b0, pinDis = 1'b0, probeReq = 1'b0;
   logic clkEn = 1'b1;
   logic regRdValid, transparent, protCheckEn, translateEn, cacheFillOk;
   logic externalCacheBlockOut_n, walkReq, walkDone, probeBusy;
   logic [31:0] regWrData = 32'h0, regRdData, physAddr, r, win [2];
   logic [2:0] probeLevel = 3'h0, dly = 3'h0;
   ttw_pkg::ttw_reg_sel_t regSel = ttw_pkg::TTW_SEL_NONE;
   ttw_pkg::ttw_access_t acc = '0, probeAcc = '0, a;
   ttw_pkg::ttw_cache_t cacheRes = '0;
   ttw_pkg::ttw_walk_t walkRes, resIn = '0;
   int badCount = 0, checksDone = 0, cycles = 0;
   integer seed = 32'hE060C032;

   ttw_top ttw_top_inst (.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(clkEn),
      .regWrEn(regWrEn), .regRdEn(regRdEn), .regSel(regSel), .regWrData(regWrData),
      .regRdData(regRdData), .regRdValid(regRdValid), .accValid(accValid), .acc(acc),
      .tcEnable(tcEnable), .translationDisablePin(pinDis), .transparent(transparent),
      .physAddr(physAddr), .protCheckEn(protCheckEn), .translateEn(translateEn),
      .cacheFillOk(cacheFillOk), .externalCacheBlockOut_n(externalCacheBlockOut_n),
      .probeReq(probeReq), .probeLevel(probeLevel), .probeAcc(probeAcc),
      .cacheRes(cacheRes), .walkReq(walkReq), .walkDone(walkDone), .walkRes(walkRes),
      .probeBusy(probeBusy));

   ttw_walker_model ttw_walker_model_inst (.clk_sys(clk_sys), .rst_n(rst_n),
      .walkReq(walkReq), .delay(dly), .resIn(resIn), .walkDone(walkDone),
      .walkRes(walkRes));

   always #20 clk_sys = ~clk_sys;

   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         badCount++;
         endSim();
      end
   end

   task automatic endSim();
      if (badCount == 0 && checksDone > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp) begin
         badCount++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // ------------------------------------------------
   // Reference model
   // ------------------------------------------------
   function automatic logic winHit(logic [31:0] w, ttw_pkg::ttw_access_t x);
      return w[15] && (((w[31:24] ^ x.addr[31:24]) & ~w[23:16]) == 8'h00)
         && (((w[6:4] ^ x.fc) & ~w[2:0]) == 3'h0)
         && (w[8] || (!x.isRmw && w[9] == x.isRead));
   endfunction

   function automatic logic [15:0] st(logic b, l, s, w, i, m, t, logic [2:0] n);
      return {b, l, s, 1'b0, w, i, m, 2'b00, t, 3'b000, n};
   endfunction

   task automatic regWr(input ttw_pkg::ttw_reg_sel_t s, input logic [31:0] d);
      @(posedge clk_sys);
      regWrEn <= 1'b1;
      regSel <= s;
      regWrData <= d;
      @(posedge clk_sys);
      regWrEn <= 1'b0;
   endtask

   task automatic regRd(input ttw_pkg::ttw_reg_sel_t s, input logic [31:0] e, m);
      @(posedge clk_sys);
      regRdEn <= 1'b1;
      regSel <= s;
      @(posedge clk_sys);
      regRdEn <= 1'b0;
      @(negedge clk_sys);
      chk(32'(regRdValid), 32'h1);
      chk(regRdData & m, e & m);
   endtask

   task automatic look(input logic v, tc);
      logic h0, h1, t, cb;
      @(posedge clk_sys);
      accValid <= v;
      acc <= a;
      tcEnable <= tc;
      @(negedge clk_sys);
      h0 = winHit(win[0], a);
      h1 = winHit(win[1], a);
      t = v & (h0 | h1);
      cb = v & ((h0 & win[0][10]) | (h1 & win[1][10]));
      chk(32'(transparent), 32'(t));
      chk(physAddr, a.addr);
      chk(32'({protCheckEn, translateEn}), 32'({v & !t, v & tc & !pinDis & !t}));
      chk(32'({cacheFillOk, externalCacheBlockOut_n}), 32'({v & !cb, !cb}));
   endtask

   task automatic probe(input logic [2:0] lvl);
      ttw_pkg::ttw_cache_t c;
      ttw_pkg::ttw_walk_t w;
      logic [15:0] e;
      logic i;
      int n;
      c = 4'($random(seed));
      w = 9'($random(seed));
      @(posedge clk_sys);
      probeReq <= 1'b1;
      regWrEn <= (lvl == 3'h0);
      regSel <= ttw_pkg::TTW_SEL_STATUS;
      regWrData <= 32'hFFFFFFFF;
      probeLevel <= lvl;
      probeAcc <= a;
      cacheRes <= c;
      resIn <= w;
      dly <= 3'($random(seed));
      @(posedge clk_sys);
      probeReq <= 1'b0;
      regWrEn <= 1'b0;
      if (lvl == 3'h0) begin
         i = !c.hit | c.busErr;
         e = st(c.hit & c.busErr, 1'b0, 1'b0, c.wp, i, c.modified, 1'b0, 3'h0);
         if (winHit(win[0], a) | winHit(win[1], a))
            regRd(ttw_pkg::TTW_SEL_STATUS, 32'h40, 32'h40);
         else
            regRd(ttw_pkg::TTW_SEL_STATUS, e, i ? 32'hF5FF : 32'hFFFF);
      end else begin
         i = w.dtInvalid | w.busErr | w.limitHit;
         e = st(w.busErr, w.limitHit, w.superSeen & !a.fc[2], w.wpSeen, i, w.modified,
            1'b0, w.tables);
         @(negedge clk_sys);
         chk(32'({walkReq, probeBusy}), 32'h3);
         n = 0;
         while (walkDone !== 1'b1 && n < 20) begin
            @(negedge clk_sys);
            n++;
         end
         chk(32'(walkDone), 32'h1);
         regRd(ttw_pkg::TTW_SEL_STATUS, e, i ? 32'hD5FF : 32'hFFFF);
         chk(32'({walkReq, probeBusy}), 32'h0);
      end
   endtask

   // ------------------------------------------------
   // Stimulus
   // ------------------------------------------------
   initial begin
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      for (int s = 0; s < 4; s++)
         regRd(ttw_pkg::ttw_reg_sel_t'(s), 32'h0, 32'hFFFFFFFF);
      regWr(ttw_pkg::TTW_SEL_WIN1, 32'hFFFFFFFF);
      regRd(ttw_pkg::TTW_SEL_WIN1, 32'hFFFF8777, 32'hFFFFFFFF);
      regWr(ttw_pkg::TTW_SEL_WIN0, 32'hFFFFFFFF);
      win[0] = 32'hFFFF8777;
      win[1] = 32'hFFFF8777;
      a = '0;
      a.addr = $random(seed);
      look(1'b1, 1'b1);
      regWr(ttw_pkg::TTW_SEL_STATUS, 32'hFFFFFFFF);
      regRd(ttw_pkg::TTW_SEL_STATUS, 32'h0000EE47, 32'hFFFFFFFF);
      for (int g = 0; g < 40; g++) begin
         for (int k = 0; k < 2; k++) begin
            r = $random(seed);
            win[k] = r & `TTW_WIN_WRITE_MASK;
            regWr(k ? ttw_pkg::TTW_SEL_WIN1 : ttw_pkg::TTW_SEL_WIN0, r);
         end
         @(posedge clk_sys);
         pinDis <= r[4];
         repeat (3) @(posedge clk_sys);
         for (int k = 0; k < 10; k++) begin
            r = $random(seed);
            a.addr = $random(seed);
            if (r[0])
               a.addr[31:24] = win[r[1]][31:24];
            a.fc = r[4:2];
            a.isRead = r[5];
            a.isRmw = r[6] & r[7];
            look(r[10:8] != 3'h0, r[11]);
         end
         probe(3'h0);
         probe(r[14:12] == 3'h0 ? 3'h7 : r[14:12]);
      end
      regWr(ttw_pkg::TTW_SEL_WIN0, 32'h00008000);
      @(posedge clk_sys);
      rst_n <= 1'b0;
      @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      clkEn <= 1'b0;
      regWr(ttw_pkg::TTW_SEL_WIN0, 32'hFFFFFFFF);
      clkEn <= 1'b1;
      regRd(ttw_pkg::TTW_SEL_WIN0, 32'h0, 32'hFFFFFFFF);
      win[0] = 32'h0;
      win[1] = 32'h0;
      look(1'b1, 1'b1);
      endSim();
   end
endmodule

`default_nettype wire

//--- ttw_consts.svh
`ifndef TTW_CONSTS_SVH
`define TTW_CONSTS_SVH

// ----------------------------------------------------------------
// Window register layout
// ----------------------------------------------------------------
`define TTW_WIN_LA_BASE_HI   31
`define TTW_WIN_LA_BASE_LO   24
`define TTW_WIN_LA_MASK_HI   23
`define TTW_WIN_LA_MASK_LO   16
`define TTW_WIN_ENABLE_BIT   15
`define TTW_WIN_CBLOCK_BIT   10
`define TTW_WIN_DIR_BIT      9
`define TTW_WIN_DIRIGN_BIT   8
`define TTW_WIN_FUNCTION_CODE_MATCH_HI   6
`define TTW_WIN_FUNCTION_CODE_MATCH_LO   4
`define TTW_WIN_FUNCTION_CODE_IGNORE_HI   2
`define TTW_WIN_FUNCTION_CODE_IGNORE_LO   0
`define TTW_WIN_WRITE_MASK   32'hFFFF_8777
`define TTW_WIN_RESET        32'h0000_0000

// ----------------------------------------------------------------
// Probe status layout
// ----------------------------------------------------------------
`define TTW_ST_BUSERR_BIT    15
`define TTW_ST_LIMIT_BIT     14
`define TTW_ST_SUPER_BIT     13
`define TTW_ST_WPROT_BIT     11
`define TTW_ST_INVALID_BIT   10
`define TTW_ST_MODIFIED_BIT  9
`define TTW_ST_TRANSP_BIT    6
`define TTW_ST_LEVELS_HI     2
`define TTW_ST_LEVELS_LO     0
`define TTW_ST_WRITE_MASK    16'hEE47
`define TTW_ST_RESET         16'h0000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TTW_SYNC_STAGES      2

`endif

//--- ttw_pkg.sv
package ttw_pkg;

   // Window register, bit for bit
   typedef struct packed {
      logic [7:0] laBase;
      logic [7:0] laMask;
      logic       enable;
      logic [3:0] rsvdA;
      logic       cacheBlock;
      logic       rwDir;
      logic       dirIgnore;
      logic       rsvdB;
      logic [2:0] fcMatch;
      logic       rsvdC;
      logic [2:0] fcIgnore;
   } ttw_window_t;

   // One access or probe looked up against the windows
   typedef struct packed {
      logic [31:0] addr;
      logic [2:0]  fc;
      logic        isRead;
      logic        isRmw;
   } ttw_access_t;

   // Translation cache lookup result for a level-0 probe
   typedef struct packed {
      logic hit;
      logic busErr;
      logic wp;
      logic modified;
   } ttw_cache_t;

   // Table walk summary for a level 1..7 probe
   typedef struct packed {
      logic       busErr;
      logic       limitHit;
      logic       superSeen;
      logic       wpSeen;
      logic       dtInvalid;
      logic       modified;
      logic [2:0] tables;
   } ttw_walk_t;

   typedef enum logic [1:0] {
      TTW_SEL_WIN0,
      TTW_SEL_WIN1,
      TTW_SEL_STATUS,
      TTW_SEL_NONE
   } ttw_reg_sel_t;

   typedef enum logic {
      TTW_PR_IDLE,
      TTW_PR_WALK
   } ttw_probe_state_t;

endpackage

//--- ttw_probe_status.sv
`timescale 1ns/100ps
`default_nettype none
`include "ttw_consts.svh"

module ttw_probe_status (
   // Clock and reset
   input  wire logic               clk_sys,
   input  wire logic               rst_n,
   input  wire logic               clkEn,
   // Software access
   input  wire logic               swWrite,
   input  wire logic [15:0]        swData,
   // Probe result
   input  wire logic               load,
   input  wire logic               isWalk,
   input  wire logic               fcTop,
   input  wire logic               transpHit,
   input  wire ttw_pkg::ttw_cache_t cacheRes,
   input  wire ttw_pkg::ttw_walk_t  walkRes,
   // Register
   output logic [15:0]             status_q
);

   logic [15:0] status_d;
   logic        stBus;
   logic        stLim;

   always_comb begin
      status_d = `TTW_ST_RESET;
      stBus    = 1'b0;
      stLim    = 1'b0;
      if (isWalk) begin
         stBus = walkRes.busErr;
         stLim = walkRes.limitHit;
         status_d[`TTW_ST_BUSERR_BIT]   = stBus;
         status_d[`TTW_ST_LIMIT_BIT]    = stLim;
         status_d[`TTW_ST_SUPER_BIT]    = walkRes.superSeen & ~fcTop;
         status_d[`TTW_ST_WPROT_BIT]    = walkRes.wpSeen;
         status_d[`TTW_ST_INVALID_BIT]  = walkRes.dtInvalid | stBus | stLim;
         status_d[`TTW_ST_MODIFIED_BIT] = walkRes.modified;
         status_d[`TTW_ST_LEVELS_HI:`TTW_ST_LEVELS_LO] = walkRes.tables;
      end else if (transpHit) begin
         status_d[`TTW_ST_TRANSP_BIT] = 1'b1;
      end else begin
         status_d[`TTW_ST_BUSERR_BIT]   = cacheRes.hit & cacheRes.busErr;
         status_d[`TTW_ST_WPROT_BIT]    = cacheRes.hit & cacheRes.wp;
         status_d[`TTW_ST_INVALID_BIT]  = ~cacheRes.hit | cacheRes.busErr;
         status_d[`TTW_ST_MODIFIED_BIT] = cacheRes.hit & cacheRes.modified;
      end
   end

   // Probe load wins over a software write in the same cycle
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         status_q <= `TTW_ST_RESET;
      end else if (clkEn) begin
         if (load) begin
            status_q <= status_d;
         end else if (swWrite) begin
            status_q <= swData & `TTW_ST_WRITE_MASK;
         end
      end
   end

   a_level0_limit: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clkEn && load && !isWalk) |=> !status_q[`TTW_ST_LIMIT_BIT]
         && status_q[`TTW_ST_LEVELS_HI:`TTW_ST_LEVELS_LO] == 3'h0)
      else $error("level-0 probe left limit or level count set");

   a_walk_transp_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clkEn && load && isWalk) |=> !status_q[`TTW_ST_TRANSP_BIT])
      else $error("walk probe set transparent status");

endmodule

`default_nettype wire

//--- ttw_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "ttw_consts.svh"

module ttw_top (
   // Clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  rst_n,
   input  wire logic                  clkEn,
   // Register move port
   input  wire logic                  regWrEn,
   input  wire logic                  regRdEn,
   input  wire ttw_pkg::ttw_reg_sel_t regSel,
   input  wire logic [31:0]           regWrData,
   output logic [31:0]                regRdData,
   output logic                       regRdValid,
   // Core access lookup
   input  wire logic                  accValid,
   input  wire ttw_pkg::ttw_access_t  acc,
   input  wire logic                  tcEnable,
   input  wire logic                  translationDisablePin,
   output logic                       transparent,
   output logic [31:0]                physAddr,
   output logic                       protCheckEn,
   output logic                       translateEn,
   output logic                       cacheFillOk,
   output logic                       externalCacheBlockOut_n,
   // Translation probe
   input  wire logic                  probeReq,
   input  wire logic [2:0]            probeLevel,
   input  wire ttw_pkg::ttw_access_t  probeAcc,
   input  wire ttw_pkg::ttw_cache_t   cacheRes,
   output logic                       walkReq,
   input  wire logic                  walkDone,
   input  wire ttw_pkg::ttw_walk_t    walkRes,
   output logic                       probeBusy
);

   // ----------------------------------------------------------------
   // Window registers
   // ----------------------------------------------------------------
   ttw_pkg::ttw_window_t win_q [2];
   ttw_pkg::ttw_access_t look  [4];
   logic [3:0]           winHit;
   logic [3:0]           winBlock;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         win_q[0] <= `TTW_WIN_RESET;
         win_q[1] <= `TTW_WIN_RESET;
      end else if (clkEn && regWrEn) begin
         if (regSel == ttw_pkg::TTW_SEL_WIN0) begin
            win_q[0] <= regWrData & `TTW_WIN_WRITE_MASK;
         end
         if (regSel == ttw_pkg::TTW_SEL_WIN1) begin
            win_q[1] <= regWrData & `TTW_WIN_WRITE_MASK;
         end
      end
   end

   // ----------------------------------------------------------------
   // Window matching: entries 0,1 core access, 2,3 probe
   // ----------------------------------------------------------------
   assign look[0] = acc;
   assign look[1] = acc;
   assign look[2] = probeAcc;
   assign look[3] = probeAcc;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_match
         ttw_window_match u_match (
            .win        (win_q[gi % 2]),
            .acc        (look[gi]),
            .hit        (winHit[gi]),
            .cacheBlock (winBlock[gi])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Disable pin synchroniser
   // ----------------------------------------------------------------
   logic disMeta_q;
   logic disSync_q;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         disMeta_q <= 1'b0;
         disSync_q <= 1'b0;
      end else if (clkEn) begin
         disMeta_q <= translationDisablePin;
         disSync_q <= disMeta_q;
      end
   end

   // ----------------------------------------------------------------
   // Core access result, same cycle as lookup
   // ----------------------------------------------------------------
   logic accBlock;

   assign transparent  = accValid & (winHit[0] | winHit[1]);
   assign accBlock     = accValid & (winBlock[0] | winBlock[1]);
   assign physAddr     = acc.addr;
   assign protCheckEn  = accValid & ~transparent;
   assign translateEn  = accValid & tcEnable & ~disSync_q & ~transparent;
   assign cacheFillOk  = accValid & ~accBlock;
   assign externalCacheBlockOut_n = ~accBlock;

   // ----------------------------------------------------------------
   // Probe sequencing
   // ----------------------------------------------------------------
   ttw_pkg::ttw_probe_state_t state_q;
   ttw_pkg::ttw_probe_state_t state_d;
   logic [2:0]                pendFc_q;
   logic                      stLoad;
   logic                      stWalk;
   logic                      probeTransp;
   logic [15:0]               status_q;

   always_comb begin
      state_d = state_q;
      stLoad  = 1'b0;
      stWalk  = 1'b0;
      case (state_q)
         ttw_pkg::TTW_PR_IDLE: begin
            if (probeReq && probeLevel == 3'h0) begin
               stLoad = 1'b1;
            end else if (probeReq) begin
               state_d = ttw_pkg::TTW_PR_WALK;
            end
         end
         ttw_pkg::TTW_PR_WALK: begin
            stWalk = 1'b1;
            if (walkDone) begin
               stLoad  = 1'b1;
               state_d = ttw_pkg::TTW_PR_IDLE;
            end
         end
         default: begin
            state_d = ttw_pkg::TTW_PR_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ttw_pkg::TTW_PR_IDLE;
      end else if (clkEn) begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pendFc_q <= 3'h0;
      end else if (clkEn && probeReq && state_q == ttw_pkg::TTW_PR_IDLE) begin
         pendFc_q <= probeAcc.fc;
      end
   end

   assign walkReq     = state_q == ttw_pkg::TTW_PR_WALK;
   assign probeBusy   = walkReq;
   assign probeTransp = winHit[2] | winHit[3];

   // Cache result is only read here; no cache update path exists
   ttw_probe_status u_status (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .clkEn     (clkEn),
      .swWrite   (regWrEn && regSel == ttw_pkg::TTW_SEL_STATUS),
      .swData    (regWrData[15:0]),
      .load      (stLoad),
      .isWalk    (stWalk),
      .fcTop     (pendFc_q[2]),
      .transpHit (probeTransp),
      .cacheRes  (cacheRes),
      .walkRes   (walkRes),
      .status_q  (status_q)
   );

   // ----------------------------------------------------------------
   // Register read port
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         regRdData  <= 32'h0000_0000;
         regRdValid <= 1'b0;
      end else if (clkEn) begin
         regRdValid <= regRdEn;
         if (regRdEn) begin
            case (regSel)
               ttw_pkg::TTW_SEL_WIN0:   regRdData <= win_q[0];
               ttw_pkg::TTW_SEL_WIN1:   regRdData <= win_q[1];
               ttw_pkg::TTW_SEL_STATUS: regRdData <= {16'h0000, status_q};
               default:                 regRdData <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence s_walk_start;
      clkEn && state_q == ttw_pkg::TTW_PR_IDLE && probeReq && probeLevel != 3'h0;
   endsequence

   sequence s_walk_end_err;
      clkEn && walkReq && walkDone && (walkRes.busErr || walkRes.limitHit);
   endsequence

   sequence s_walk_end;
      clkEn && walkReq && walkDone;
   endsequence

   a_la_compare: assert property (
      (win_q[0].enable && win_q[0].laMask == 8'h00
       && acc.addr[31:24] != win_q[0].laBase) |-> !winHit[0])
      else $error("window 0 hit on differing address");

   a_la_mask_wide: assert property (
      (accValid && win_q[1].enable && win_q[1].laMask == 8'hFF
       && win_q[1].fcIgnore == 3'h7 && win_q[1].dirIgnore) |-> transparent)
      else $error("fully masked window 1 missed");

   a_fc_compare: assert property (
      (win_q[0].fcIgnore == 3'h0 && acc.fc != win_q[0].fcMatch) |-> !winHit[0])
      else $error("window 0 hit on differing function code");

   a_pass_through: assert property (
      transparent |-> physAddr == acc.addr && !protCheckEn && !translateEn)
      else $error("transparent access translated or checked");

   a_enable_gate: assert property (
      (!win_q[0].enable && !win_q[1].enable) |-> !transparent)
      else $error("disabled windows produced a hit");

   a_cache_block: assert property (
      (accValid && winBlock[0]) |-> !cacheFillOk && !externalCacheBlockOut_n)
      else $error("cache block not applied on hit");

   a_dir_select: assert property (
      (!win_q[1].dirIgnore && (acc.isRead != win_q[1].rwDir)) |-> !winHit[1])
      else $error("window 1 passed wrong direction");

   a_rmw_block: assert property (
      (acc.isRmw && !win_q[0].dirIgnore) |-> !winHit[0])
      else $error("rmw passed with direction in use");

   a_either_hit: assert property (
      (accValid && (winHit[0] || winHit[1])) |-> transparent)
      else $error("window hit not reported as transparent");

   a_walk_handshake: assert property (
      s_walk_start |=> walkReq && probeBusy)
      else $error("walk probe did not request walk");

   a_walk_error_inv: assert property (
      s_walk_end_err |=> status_q[`TTW_ST_INVALID_BIT] && !walkReq)
      else $error("walk error did not set invalid");

   a_level0_transp: assert property (
      (clkEn && state_q == ttw_pkg::TTW_PR_IDLE && probeReq
       && probeLevel == 3'h0 && probeTransp) |=> status_q[`TTW_ST_TRANSP_BIT])
      else $error("level-0 window hit not reported");

   a_dir_ignore: assert property (
      (win_q[0].enable && win_q[0].dirIgnore && win_q[0].laMask == 8'hFF
       && win_q[0].fcIgnore == 3'h7) |-> winHit[0])
      else $error("window 0 with direction ignored missed");

   a_walk_levels: assert property (
      s_walk_end |=> status_q[`TTW_ST_LEVELS_HI:`TTW_ST_LEVELS_LO] == $past(walkRes.tables))
      else $error("walk level count not loaded");

endmodule

`default_nettype wire

//--- ttw_walker_model.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------
// Table walker stand-in
// ------------------------------------------------
module ttw_walker_model (
   // Clock and reset
   input  wire logic               clk_sys,
   input  wire logic               rst_n,
   // Walk handshake
   input  wire logic               walkReq,
   input  wire logic [2:0]         delay,
   input  wire ttw_pkg::ttw_walk_t resIn,
   output logic                    walkDone,
   output ttw_pkg::ttw_walk_t      walkRes
);
   logic [2:0] cnt_q;

   // Result only valid in the done cycle
   assign walkRes = walkDone ? resIn : ~resIn;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q    <= 3'h0;
         walkDone <= 1'b0;
      end else begin
         walkDone <= 1'b0;
         cnt_q    <= 3'h0;
         if (walkReq && !walkDone) begin
            if (cnt_q == delay)
               walkDone <= 1'b1;
            else
               cnt_q <= cnt_q + 3'h1;
         end
      end
   end
endmodule

`default_nettype wire

//--- ttw_window_match.sv
`timescale 1ns/100ps
`default_nettype none

module ttw_window_match (
   // Window and lookup
   input  wire ttw_pkg::ttw_window_t win,
   input  wire ttw_pkg::ttw_access_t acc,
   // Result
   output logic                      hit,
   output logic                      cacheBlock
);

   logic laOk;
   logic fcOk;
   logic dirOk;

   assign laOk  = ((win.laBase ^ acc.addr[31:24]) & ~win.laMask) == 8'h00;
   assign fcOk  = ((win.fcMatch ^ acc.fc) & ~win.fcIgnore) == 3'h0;
   assign dirOk = win.dirIgnore
                  | (!acc.isRmw && (acc.isRead == win.rwDir));
   assign hit        = win.enable & laOk & fcOk & dirOk;
   assign cacheBlock = hit & win.cacheBlock;

endmodule

`default_nettype wire
